// *** verilog/ome_pkg.sv ***
// shared constants and types for the on-chip ram access block
package ome_pkg;

  // ***********************************
  // widths
  // ***********************************
  localparam int DATA_W = 32;
  localparam int CODE_W = 39;
  localparam int ADDR_W = 32;
  localparam int CNT_W  = 3;

  // ***********************************
  // address map and array depths
  // ***********************************
  localparam logic [ADDR_W-1:0] RAM_BASE  = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] RAM_LAST  = 32'h0001_ffff;
  localparam logic [ADDR_W-1:0] ECC_BASE  = 32'h00ff_c000;
  localparam logic [ADDR_W-1:0] ECC_LAST  = 32'h00ff_ffff;
  localparam int                RAM_WORDS = 32768;
  localparam int                ECC_WORDS = 4096;

  // ***********************************
  // access latencies in cycles
  // ***********************************
  localparam logic [CNT_W-1:0] LAT_RAM      = 3'h1;
  localparam logic [CNT_W-1:0] LAT_ECC_W0   = 3'h2;
  localparam logic [CNT_W-1:0] LAT_ECC_W1   = 3'h3;
  localparam logic [CNT_W-1:0] LAT_ECC_WR1  = 3'h4;
  localparam logic [CNT_W-1:0] LAT_ERR_W0   = 3'h3;
  localparam logic [CNT_W-1:0] LAT_ERR_W1   = 3'h5;
  localparam logic [CNT_W-1:0] CNT_CHECK    = 3'h1;
  localparam logic [CNT_W-1:0] CNT_REPORT   = 3'h2;

  // ***********************************
  // flag clear bit positions and reset values
  // ***********************************
  localparam int CLR_RAM  = 0;
  localparam int CLR_ECC1 = 1;
  localparam int CLR_ECC2 = 2;
  localparam int CLR_LOST = 3;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {TGT_NONE, TGT_RAM, TGT_ECC} ome_tgt_e;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ome_req_s;

  typedef struct packed {
    logic              flag;
    logic [ADDR_W-1:0] addr;
  } ome_err_s;

endpackage

// *** verilog/ome_secded.sv ***
// single-error-correct double-error-detect code for one 32-bit word
`timescale 1ns/1ps
module ome_secded
  import ome_pkg::*;
(
  // encode side
  input  wire logic [DATA_W-1:0] enc_data,
  output logic      [CODE_W-1:0] enc_code,
  // decode side
  input  wire logic [CODE_W-1:0] dec_code,
  output logic      [DATA_W-1:0] dec_raw,
  output logic      [DATA_W-1:0] dec_fixed,
  output logic                   dec_single,
  output logic                   dec_double
);

  // ***********************************
  // helpers
  // ***********************************
  // bit 0 is overall parity, hamming positions 1..38, checks at powers of two
  function automatic logic is_check(input int p);
    return (p & (p - 1)) == 0;
  endfunction

  function automatic logic [DATA_W-1:0] extract(input logic [CODE_W-1:0] c);
    logic [DATA_W-1:0] d;
    int                k;
    d = '0;
    k = 0;
    for (int p = 1; p < CODE_W; p++) begin
      if (!is_check(p)) begin
        d[k] = c[p];
        k++;
      end
    end
    return d;
  endfunction

  function automatic logic [5:0] syndrome(input logic [CODE_W-1:0] c);
    logic [5:0] s;
    s = '0;
    for (int p = 1; p < CODE_W; p++) begin
      if (c[p]) begin
        s = s ^ p[5:0];
      end
    end
    return s;
  endfunction

  // ***********************************
  // encoder
  // ***********************************
  logic [CODE_W-1:0] body;
  logic [5:0]        chk;

  always_comb begin
    int k;
    k    = 0;
    body = '0;
    for (int p = 1; p < CODE_W; p++) begin
      if (!is_check(p)) begin
        body[p] = enc_data[k];
        k++;
      end
    end
    chk = syndrome(body);
    for (int b = 0; b < 6; b++) begin
      body[1 << b] = chk[b];
    end
    enc_code = {body[CODE_W-1:1], ^body[CODE_W-1:1]};
  end

  // ***********************************
  // decoder
  // ***********************************
  wire logic [5:0]        syn     = syndrome(dec_code);
  wire logic              ovr     = ^dec_code;
  // a syndrome beyond the word can only come from several flipped bits
  wire logic              syn_out = syn >= 6'(CODE_W);
  wire logic [CODE_W-1:0] flip    = (ovr && !syn_out) ? (39'h1 << syn) : '0;

  assign dec_raw    = extract(dec_code);
  assign dec_fixed  = extract(dec_code ^ flip);
  assign dec_single = ovr && !syn_out;
  assign dec_double = (!ovr && syn != 6'h0) || (ovr && syn_out);

endmodule

// *** verilog/ome_err_log.sv ***
// sticky error flag with captured address
`timescale 1ns/1ps
module ome_err_log
  import ome_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // event and clear
  input  wire logic              set,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              clr,
  // state
  output ome_err_s               log
);

  logic              flag_q;
  logic [ADDR_W-1:0] addr_q;

  // [RULE_15] flag and address capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      addr_q <= ADDR_RST;
    end else begin
      // an event in the clearing cycle must not be lost
      flag_q <= set | (flag_q & ~clr);
      if (set) begin
        addr_q <= addr;
      end
    end
  end

  assign log = '{flag: flag_q, addr: addr_q};

endmodule

// *** verilog/ome_ram_ctrl.sv ***
// access logic for the plain parity ram and the ecc-protected ram
// Operation
// [RULE_01] plain ram at 0000_0000 to 0001_ffff
// [RULE_02] protected ram at 00ff_c000 to 00ff_ffff
// [RULE_03] plain ram completes in one cycle
// [RULE_04] plain ram can be enabled or disabled
// [RULE_05] ecc function switched on or off
// [RULE_06] wait zero, no error: two cycles
// [RULE_07] wait zero, ecc error: three cycles
// [RULE_08] wait one: three cycles, ecc write four
// [RULE_09] wait one, ecc error: five cycles
// [RULE_10] separate module stop for each ram
// [RULE_11] plain ram detects single-bit errors
// [RULE_12] protected ram corrects single, detects double
// [RULE_13] errors raise nmi or maskable interrupt
// [RULE_14] no retention through deep software standby
// [RULE_15] separate single/double flags with addresses
// [RULE_16] corrected word returned in same access
// [RULE_17] disabled or stopped ram keeps contents
`timescale 1ns/1ps
module ome_ram_ctrl
  import ome_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_WORDS,
  parameter int ECC_DEPTH = ECC_WORDS
)(
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  // memory bus
  input  wire logic              BUS_REQ,
  input  wire logic              BUS_WE,
  input  wire logic [ADDR_W-1:0] BUS_ADDR,
  input  wire logic [DATA_W-1:0] BUS_WDATA,
  output logic                   BUS_READY,
  output logic                   BUS_REFUSED,
  output logic      [DATA_W-1:0] BUS_RDATA,
  // configuration
  input  wire logic              RAM_ENABLE,
  input  wire logic              ECC_ENABLE,
  input  wire logic              MEM_WAIT,
  input  wire logic              RAM_STOP,
  input  wire logic              ECC_STOP,
  input  wire logic              ECC1_LOG_EN,
  input  wire logic              ERR_TO_NMI,
  input  wire logic              DEEP_STBY,
  // status
  input  wire logic [3:0]        FLAG_CLR,
  output logic                   RAM_ERR_FLAG,
  output logic      [ADDR_W-1:0] RAM_ERR_ADDR,
  output logic                   ECC1_ERR_FLAG,
  output logic      [ADDR_W-1:0] ECC1_ERR_ADDR,
  output logic                   ECC2_ERR_FLAG,
  output logic      [ADDR_W-1:0] ECC2_ERR_ADDR,
  output logic                   CONTENT_LOST,
  // interrupts
  output logic                   NMI_REQ,
  output logic                   IRQ_REQ
);

  localparam int RIW = $clog2(RAM_DEPTH);
  localparam int EIW = $clog2(ECC_DEPTH);

  typedef enum logic {ST_IDLE, ST_BUSY} ome_state_e;

  // ***********************************
  // latency selection
  // ***********************************
  function automatic logic [CNT_W-1:0] ecc_latency(input logic ecc_on, input logic wt,
                                                   input logic we, input logic err);
    logic [CNT_W-1:0] lat;
    if (err) begin
      lat = wt ? LAT_ERR_W1 : LAT_ERR_W0;
    end else if (ecc_on && wt && we) begin
      lat = LAT_ECC_WR1;
    end else begin
      lat = wt ? LAT_ECC_W1 : LAT_ECC_W0;
    end
    return lat;
  endfunction

  // bit 0 and the power-of-two positions hold the check bits
  function automatic logic [CODE_W-1:0] check_mask();
    logic [CODE_W-1:0] m;
    m = '0;
    for (int p = 0; p < CODE_W; p++) begin
      m[p] = (p & (p - 1)) == 0;
    end
    return m;
  endfunction

  // ***********************************
  // storage
  // ***********************************
  logic [DATA_W:0]   ram_mem [RAM_DEPTH];
  logic [CODE_W-1:0] ecc_mem [ECC_DEPTH];

  // ***********************************
  // state
  // ***********************************
  ome_state_e        state_q;
  ome_tgt_e          tgt_q;
  ome_req_s          req_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              ecc_on_q;
  logic              wait_q;
  logic              err1_q;
  logic              err2_q;
  logic [DATA_W-1:0] rdata_q;
  logic              par_q;
  logic [CODE_W-1:0] raw_q;
  logic              lost_q;

  // ***********************************
  // decode
  // ***********************************
  wire logic [ADDR_W-1:0] ram_off = BUS_ADDR - RAM_BASE;
  wire logic [ADDR_W-1:0] ecc_off = BUS_ADDR - ECC_BASE;
  // [RULE_01] plain ram window
  wire logic              ram_hit = BUS_ADDR <= RAM_LAST;
  // [RULE_02] protected ram window
  wire logic              ecc_hit = BUS_ADDR >= ECC_BASE && BUS_ADDR <= ECC_LAST;
  // [RULE_04] [RULE_10] disable and module stop gate access
  wire logic              ram_ok  = ram_hit && RAM_ENABLE && !RAM_STOP;
  wire logic              ecc_ok  = ecc_hit && !ECC_STOP;
  // [RULE_14] nothing is taken while the arrays are unpowered
  wire logic              take    = BUS_REQ && state_q == ST_IDLE && !DEEP_STBY;
  wire ome_tgt_e          tgt_d   = ram_ok ? TGT_RAM : (ecc_ok ? TGT_ECC : TGT_NONE);
  wire logic [RIW-1:0]    ram_idx = ram_off[RIW+1:2];
  wire logic [EIW-1:0]    ecc_idx = ecc_off[EIW+1:2];
  wire logic [RIW-1:0]    ram_ridx = req_q.addr[RIW+1:2];
  wire logic [EIW-1:0]    ecc_ridx = (req_q.addr[EIW+1:2] - ECC_BASE[EIW+1:2]);

  // ***********************************
  // ecc coding
  // ***********************************
  logic [CODE_W-1:0] enc_code;
  logic [DATA_W-1:0] dec_raw;
  logic [DATA_W-1:0] dec_fixed;
  logic              dec_single;
  logic              dec_double;

  ome_secded u_secded (
    .enc_data   (req_q.wdata),
    .enc_code   (enc_code),
    .dec_code   (raw_q),
    .dec_raw    (dec_raw),
    .dec_fixed  (dec_fixed),
    .dec_single (dec_single),
    .dec_double (dec_double)
  );

  // [RULE_05] ecc off stores data bits only, check bits stay clear;
  // a later ecc-on read then sees such words as bad unless their check bits would be zero anyway, which self-tests rely on
  wire logic [CODE_W-1:0] store_code = ecc_on_q ? enc_code : (enc_code & ~check_mask());

  // ***********************************
  // timing
  // ***********************************
  wire logic             busy     = state_q == ST_BUSY;
  wire logic             at_check = busy && cnt_q == CNT_CHECK;
  wire logic             at_rep   = busy && cnt_q == CNT_REPORT && tgt_q == TGT_ECC;
  // [RULE_06] [RULE_07] [RULE_08] [RULE_09] ecc latency by wait and error
  wire logic [CNT_W-1:0] ecc_lat  = ecc_latency(ecc_on_q, wait_q, req_q.we, err1_q | err2_q);
  // [RULE_03] plain and refused accesses end after one cycle
  wire logic [CNT_W-1:0] lat      = tgt_q == TGT_ECC ? ecc_lat : LAT_RAM;
  wire logic             done     = busy && cnt_q == lat;

  // ***********************************
  // error events
  // ***********************************
  // [RULE_11] even parity check on plain ram reads
  wire logic ram_err_ev  = at_check && tgt_q == TGT_RAM && !req_q.we && (^{par_q, rdata_q});
  wire logic ecc1_ev     = at_rep && err1_q;
  wire logic ecc2_ev     = at_rep && err2_q;
  wire logic any_err_ev  = ram_err_ev | (ecc1_ev & ECC1_LOG_EN) | ecc2_ev;

  // ***********************************
  // control
  // ***********************************
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q  <= ST_IDLE;
      tgt_q    <= TGT_NONE;
      req_q    <= '0;
      cnt_q    <= '0;
      ecc_on_q <= 1'b0;
      wait_q   <= 1'b0;
    end else if (take) begin
      state_q  <= ST_BUSY;
      tgt_q    <= tgt_d;
      req_q    <= '{we: BUS_WE, addr: BUS_ADDR, wdata: BUS_WDATA};
      cnt_q    <= CNT_CHECK;
      // [RULE_05] ecc switch sampled per access
      ecc_on_q <= ECC_ENABLE;
      wait_q   <= MEM_WAIT;
    end else if (done) begin
      state_q  <= ST_IDLE;
    end else if (busy) begin
      cnt_q    <= cnt_q + 3'h1;
    end
  end

  // ***********************************
  // read data and check results
  // ***********************************
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= RDATA_RST;
      err1_q  <= 1'b0;
      err2_q  <= 1'b0;
    end else if (take) begin
      rdata_q <= RDATA_RST;
      err1_q  <= 1'b0;
      err2_q  <= 1'b0;
      if (tgt_d == TGT_RAM && !BUS_WE) begin
        rdata_q <= ram_mem[ram_idx][DATA_W-1:0];
      end
    end else if (at_check && tgt_q == TGT_ECC) begin
      // [RULE_12] [RULE_16] corrected word returned in extra cycles
      rdata_q <= ecc_on_q ? dec_fixed : dec_raw;
      err1_q  <= ecc_on_q && dec_single;
      err2_q  <= ecc_on_q && dec_double;
    end
  end

  // ***********************************
  // arrays, no reset so they map onto ram macros
  // ***********************************
  always_ff @(posedge CORE_CLK) begin
    par_q <= ram_mem[ram_idx][DATA_W];
    raw_q <= ecc_mem[ecc_idx];
    // [RULE_17] only enabled running arrays are written
    if (take && tgt_d == TGT_RAM && BUS_WE) begin
      ram_mem[ram_idx] <= {^BUS_WDATA, BUS_WDATA};
    end
    // protected writes land at the end, after the old word was checked
    if (done && tgt_q == TGT_ECC && req_q.we) begin
      ecc_mem[ecc_ridx] <= store_code;
    end
  end

  // ***********************************
  // error logs
  // ***********************************
  ome_err_s ram_log;
  ome_err_s ecc1_log;
  ome_err_s ecc2_log;

  ome_err_log u_log_ram (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .set   (ram_err_ev),
    .addr  (req_q.addr),
    .clr   (FLAG_CLR[CLR_RAM]),
    .log   (ram_log)
  );

  // [RULE_15] single-bit log obeys its update enable
  ome_err_log u_log_ecc1 (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .set   (ecc1_ev && ECC1_LOG_EN),
    .addr  (req_q.addr),
    .clr   (FLAG_CLR[CLR_ECC1]),
    .log   (ecc1_log)
  );

  ome_err_log u_log_ecc2 (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .set   (ecc2_ev),
    .addr  (req_q.addr),
    .clr   (FLAG_CLR[CLR_ECC2]),
    .log   (ecc2_log)
  );

  // ***********************************
  // interrupts and standby loss
  // ***********************************
  logic nmi_q;
  logic irq_q;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      nmi_q  <= 1'b0;
      irq_q  <= 1'b0;
      lost_q <= 1'b0;
    end else begin
      // [RULE_13] route error to nmi or maskable line
      nmi_q  <= any_err_ev && ERR_TO_NMI;
      irq_q  <= any_err_ev && !ERR_TO_NMI;
      // [RULE_14] contents unknown once deep standby is entered
      lost_q <= DEEP_STBY | (lost_q & ~FLAG_CLR[CLR_LOST]);
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign BUS_READY     = done;
  assign BUS_REFUSED   = done && tgt_q == TGT_NONE;
  assign BUS_RDATA     = rdata_q;
  assign RAM_ERR_FLAG  = ram_log.flag;
  assign RAM_ERR_ADDR  = ram_log.addr;
  assign ECC1_ERR_FLAG = ecc1_log.flag;
  assign ECC1_ERR_ADDR = ecc1_log.addr;
  assign ECC2_ERR_FLAG = ecc2_log.flag;
  assign ECC2_ERR_ADDR = ecc2_log.addr;
  assign CONTENT_LOST  = lost_q;
  assign NMI_REQ       = nmi_q;
  assign IRQ_REQ       = irq_q;

endmodule

// *** verification/ome_ram_props.sv ***
// assertion checker for the on-chip ram access block
`timescale 1ns/1ps
module ome_ram_props
  import ome_pkg::*;
(
  // clock and reset
  input wire logic              CORE_CLK,
  input wire logic              RST_N,
  // memory bus
  input wire logic              BUS_REQ,
  input wire logic [ADDR_W-1:0] BUS_ADDR,
  input wire logic              BUS_READY,
  input wire logic              BUS_REFUSED,
  input wire logic [DATA_W-1:0] BUS_RDATA,
  // configuration
  input wire logic              RAM_ENABLE,
  input wire logic              ECC_ENABLE,
  input wire logic              MEM_WAIT,
  input wire logic              RAM_STOP,
  input wire logic              ECC_STOP,
  input wire logic              DEEP_STBY,
  // status
  input wire logic              RAM_ERR_FLAG,
  input wire logic              ECC2_ERR_FLAG,
  input wire logic              CONTENT_LOST,
  input wire logic              NMI_REQ,
  input wire logic              IRQ_REQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ****************
  // take tracking
  // ****************
  logic busy_q;
  // plain window starts at zero, so only the top bound is compared
  wire take    = BUS_REQ && !busy_q && !DEEP_STBY;
  wire ram_ok  = (BUS_ADDR <= RAM_LAST) && RAM_ENABLE && !RAM_STOP;
  wire ecc_ok  = (BUS_ADDR >= ECC_BASE) && (BUS_ADDR <= ECC_LAST) && !ECC_STOP;
  wire ecc_on  = take && ecc_ok && ECC_ENABLE;
  wire ecc_off = take && ecc_ok && !ECC_ENABLE;
  // the ready cycle still counts as busy, no take in it
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= take || (busy_q && !BUS_READY);
    end
  end
  // ****************
  // properties
  // ****************
  property p_plain; take && ram_ok |=> (BUS_READY && !BUS_REFUSED) ##1 !BUS_READY; endproperty
  a_plain: assert property (p_plain) else $error("plain access not one cycle");
  property p_refuse; take && !ram_ok && !ecc_ok |=> BUS_REFUSED && BUS_READY && BUS_RDATA == '0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("access not refused");
  property p_eoff0; ecc_off && !MEM_WAIT |=> !BUS_READY ##1 BUS_READY; endproperty
  a_eoff0: assert property (p_eoff0) else $error("ecc off wait0 latency");
  property p_eoff1; ecc_off && MEM_WAIT |=> !BUS_READY [*2] ##1 BUS_READY; endproperty
  a_eoff1: assert property (p_eoff1) else $error("ecc off wait1 latency");
  property p_eon0; ecc_on && !MEM_WAIT |=> !BUS_READY ##[1:2] BUS_READY; endproperty
  a_eon0: assert property (p_eon0) else $error("ecc on wait0 latency");
  property p_eon1; ecc_on && MEM_WAIT |=> !BUS_READY [*2] ##[1:3] BUS_READY; endproperty
  a_eon1: assert property (p_eon1) else $error("ecc on wait1 latency");
  property p_irq; $rose(RAM_ERR_FLAG) || $rose(ECC2_ERR_FLAG) |-> NMI_REQ ^ IRQ_REQ; endproperty
  a_irq: assert property (p_irq) else $error("error without one interrupt");
  property p_lost; DEEP_STBY |=> CONTENT_LOST; endproperty
  a_lost: assert property (p_lost) else $error("standby not marked lost");
  c_plain: cover property (take && ram_ok);
  c_ecc_w1: cover property (ecc_on && MEM_WAIT);
  c_refuse: cover property (BUS_REFUSED);
  c_ecc2: cover property ($rose(ECC2_ERR_FLAG));
endmodule

bind ome_ram_ctrl ome_ram_props props_u (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .BUS_REQ(BUS_REQ), .BUS_ADDR(BUS_ADDR),
  .BUS_READY(BUS_READY), .BUS_REFUSED(BUS_REFUSED), .BUS_RDATA(BUS_RDATA),
  .RAM_ENABLE(RAM_ENABLE), .ECC_ENABLE(ECC_ENABLE), .MEM_WAIT(MEM_WAIT),
  .RAM_STOP(RAM_STOP), .ECC_STOP(ECC_STOP), .DEEP_STBY(DEEP_STBY),
  .RAM_ERR_FLAG(RAM_ERR_FLAG), .ECC2_ERR_FLAG(ECC2_ERR_FLAG),
  .CONTENT_LOST(CONTENT_LOST), .NMI_REQ(NMI_REQ), .IRQ_REQ(IRQ_REQ)
);

// *** verification/ome_bus_master.sv ***
// memory bus master model issuing one access per go pulse
`timescale 1ns/1ps
module ome_bus_master
  import ome_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // command side
  input  wire logic              go,
  input  wire ome_req_s          cmd,
  output logic                   done,
  output logic                   ref_q,
  output logic      [DATA_W-1:0] rd_q,
  output logic      [CNT_W-1:0]  lat_q,
  // memory bus
  output logic                   bus_req,
  output ome_req_s               bus,
  input  wire logic              ready,
  input  wire logic              refused,
  input  wire logic [DATA_W-1:0] rdata
);
  ome_req_s         cur_q;
  logic [CNT_W-1:0] cnt_q;
  // released bus shows the inverse so stale values never pass
  assign bus = bus_req ? cur_q : ome_req_s'(~cur_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_req <= 1'b0;
      done    <= 1'b0;
      cur_q   <= '0;
      cnt_q   <= '0;
      ref_q   <= 1'b0;
      rd_q    <= '0;
      lat_q   <= '0;
    end else begin
      done <= 1'b0;
      if (go) begin
        bus_req <= 1'b1;
        cur_q   <= cmd;
        cnt_q   <= '0;
      end else if (bus_req && ready) begin
        bus_req <= 1'b0;
        done    <= 1'b1;
        ref_q   <= refused;
        rd_q    <= rdata;
        lat_q   <= cnt_q;
      end else if (bus_req) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end
endmodule

// *** verification/ome_ram_ctrl_test.sv ***
// self-checking testbench for the on-chip ram access block
`timescale 1ns/1ps
module ome_ram_ctrl_test
  import ome_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              go = 1'b0;
  ome_req_s          cmd = '0;
  logic              ram_en = 1'b1;
  logic              ecc_en = 1'b0;
  logic              mwait = 1'b0;
  logic              ram_stop = 1'b0;
  logic              ecc_stop = 1'b0;
  logic              stby = 1'b0;
  logic [3:0]        clr = 4'h0;
  logic              nmi_sel = 1'b0;
  logic              nmi, irq;
  logic [ADDR_W-1:0] e1_addr, e2_addr;
  logic              m_done, m_ref, b_req, b_rdy, b_ref, ram_err, e1, e2, lost;
  logic [DATA_W-1:0] m_rd, b_rd;
  logic [CNT_W-1:0]  m_lat;
  ome_req_s          b_cmd;
  int                failures = 0;
  int                num_checks = 0;
  int                n_nmi = 0;
  int                n_irq = 0;

  always #2.5 clk = ~clk;

  ome_bus_master mst_u (.clk(clk), .rst_n(rst_n), .go(go), .cmd(cmd), .done(m_done),
    .ref_q(m_ref), .rd_q(m_rd), .lat_q(m_lat), .bus_req(b_req), .bus(b_cmd),
    .ready(b_rdy), .refused(b_ref), .rdata(b_rd));
  ome_ram_ctrl dut_u (.CORE_CLK(clk), .RST_N(rst_n), .BUS_REQ(b_req), .BUS_WE(b_cmd.we),
    .BUS_ADDR(b_cmd.addr), .BUS_WDATA(b_cmd.wdata), .BUS_READY(b_rdy), .BUS_REFUSED(b_ref),
    .BUS_RDATA(b_rd), .RAM_ENABLE(ram_en), .ECC_ENABLE(ecc_en), .MEM_WAIT(mwait),
    .RAM_STOP(ram_stop), .ECC_STOP(ecc_stop), .ECC1_LOG_EN(1'b1), .ERR_TO_NMI(nmi_sel),
    .DEEP_STBY(stby), .FLAG_CLR(clr), .RAM_ERR_FLAG(ram_err), .RAM_ERR_ADDR(),
    .ECC1_ERR_FLAG(e1), .ECC1_ERR_ADDR(e1_addr), .ECC2_ERR_FLAG(e2), .ECC2_ERR_ADDR(e2_addr),
    .CONTENT_LOST(lost), .NMI_REQ(nmi), .IRQ_REQ(irq));

  // interrupt pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    n_nmi <= n_nmi + int'(nmi === 1'b1);
    n_irq <= n_irq + int'(irq === 1'b1);
  end

  // ****************
  // shared tasks
  // ****************
  task automatic wrap_up;
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    go  <= 1'b1;
    cmd <= {we, a, d};
    @(posedge clk);
    go <= 1'b0;
    while (m_done !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(n < 20, 1'b1);
  endtask
  task automatic refuse(input logic [ADDR_W-1:0] a);
    xfer(1'b1, a, 32'hdead_beef);
    chk({m_ref, m_lat}, 4'h9);
    chk(m_rd, 32'h0);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_plain;
    xfer(1'b1, RAM_BASE, 32'h1234_5678);
    chk(m_lat, 3'h1);
    xfer(1'b1, RAM_LAST - 32'h3, 32'hcafe_0001);
    xfer(1'b0, RAM_BASE, '0);
    chk(m_rd, 32'h1234_5678);
    xfer(1'b0, RAM_LAST - 32'h3, '0);
    chk(m_rd, 32'hcafe_0001);
    chk({m_lat, ram_err}, 4'h2);
  endtask
  task automatic t_ecc;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    // prime both ends with ecc off so later checks see valid codes
    xfer(1'b1, ECC_BASE, '0);
    xfer(1'b1, ECC_LAST - 32'h3, '0);
    for (int i = 0; i < 4; i++) begin
      a = i[1] ? ECC_LAST - 32'h3 : ECC_BASE;
      // ecc-off words carry clear check bits, keep them off the ecc-on words
      a = i[0] ? a : a ^ 32'h10;
      d = 32'h5a5a_0000 | i;
      @(posedge clk);
      ecc_en <= i[0];
      mwait  <= i[1];
      xfer(1'b1, a, d);
      chk(m_lat, i[0] ? (i[1] ? 4 : 2) : 2 + i[1]);
      xfer(1'b0, a, '0);
      chk(m_lat, 2 + i[1]);
      chk(m_rd, d);
    end
    chk({e1, e2}, 2'h0);
  endtask
  task automatic t_refuse;
    refuse(RAM_LAST + 32'h4);
    refuse(ECC_BASE - 32'h4);
    @(posedge clk);
    ram_en <= 1'b0;
    refuse(RAM_BASE);
    @(posedge clk);
    ram_en   <= 1'b1;
    ram_stop <= 1'b1;
    refuse(RAM_BASE);
    @(posedge clk);
    ram_stop <= 1'b0;
    ecc_stop <= 1'b1;
    refuse(ECC_BASE);
    @(posedge clk);
    ecc_stop <= 1'b0;
    xfer(1'b0, RAM_BASE, '0);
    chk(m_rd, 32'h1234_5678);
    xfer(1'b0, ECC_BASE, '0);
    chk(m_rd, 32'h5a5a_0001);
  endtask
  // write with ecc off to plant bad bits, then read back with ecc on
  task automatic plant(input logic [DATA_W-1:0] d, input logic w);
    @(posedge clk);
    ecc_en  <= 1'b0;
    mwait   <= w;
    nmi_sel <= w;
    xfer(1'b1, ECC_BASE + 32'h8, d);
    @(posedge clk);
    ecc_en <= 1'b1;
    xfer(1'b0, ECC_BASE + 32'h8, '0);
  endtask
  task automatic t_err;
    // one bad bit: corrected, one extra cycle, maskable line
    plant(32'h1, 1'b0);
    chk(m_lat, 3'h3);
    chk(m_rd, 32'h0);
    chk({e1, e2}, 2'h2);
    chk(e1_addr, ECC_BASE + 32'h8);
    chk(n_irq, 1);
    // two bad bits: detected only, raw word back, nmi line
    plant(32'h3, 1'b1);
    chk(m_lat, 3'h5);
    chk(m_rd, 32'h3);
    chk({e1, e2}, 2'h3);
    chk(e2_addr, ECC_BASE + 32'h8);
    chk(n_nmi, 1);
  endtask
  task automatic t_stby;
    @(posedge clk);
    stby <= 1'b1;
    clr  <= 4'he;
    repeat (2) @(posedge clk);
    chk(lost, 1'b1);
    stby <= 1'b0;
    repeat (2) @(posedge clk);
    clr <= 4'h0;
    chk(lost, 1'b0);
    chk({e1, e2}, 2'h0);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_plain();
    t_ecc();
    t_refuse();
    t_err();
    t_stby();
    wrap_up();
  end
  // 25 accesses of under ten cycles each, so sixteen times margin
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    $display("MISMATCH t=%0t watchdog", $time);
    wrap_up();
  end
endmodule
